// ===== pkg/bsc_pkg.sv
// Constants, cell maps and state types shared by the boundary-scan test access logic.
package bsc_pkg;

  // Chain geometry.
  localparam int BSC_CHAIN_LEN = 236;
  localparam int BSC_OEN_COUNT = 28;
  localparam int BSC_PAD_CELLS = 205;
  localparam int BSC_PAD_SIGNALS = 117;
  localparam int BSC_INT_COUNT = 3;
  localparam int BSC_RST_CLR_CELLS = 3;
  localparam int BSC_IR_W = 8;
  localparam int BSC_ID_W = 32;

  // Instruction codes.
  localparam logic [BSC_IR_W-1:0] BSC_INS_EXTEST = 8'h00;
  localparam logic [BSC_IR_W-1:0] BSC_INS_SAMPLE = 8'h01;
  localparam logic [BSC_IR_W-1:0] BSC_INS_IDCODE = 8'h03;
  localparam logic [BSC_IR_W-1:0] BSC_INS_BYPASS = 8'hFF;
  localparam logic [BSC_IR_W-1:0] BSC_IR_CAPTURE = 8'h01;

  // Identification code; the value is arbitrary and carries no maker meaning.
  localparam logic [BSC_ID_W-1:0] BSC_IDCODE_DEFAULT = 32'h1357_9BDF;

  // Cell numbers count from 1 at the serial input; cell n sits at bit BSC_CHAIN_LEN - n.
  localparam int BSC_OEN_CELL [BSC_OEN_COUNT] = '{
    6, 15, 24, 33, 42, 50, 57, 66, 77, 84, 89, 94, 110, 115,
    127, 136, 144, 153, 164, 167, 180, 186, 193, 198, 203, 212, 221, 233};
  localparam int BSC_INT_CELL [BSC_INT_COUNT] = '{1, 128, 131};

  // Marks the output-enable cells of the chain.
  function automatic logic [BSC_CHAIN_LEN-1:0] bsc_oen_mask();
    logic [BSC_CHAIN_LEN-1:0] m;
    m = '0;
    for (int i = 0; i < BSC_OEN_COUNT; i++) begin
      m[BSC_CHAIN_LEN - BSC_OEN_CELL[i]] = 1'b1;
    end
    return m;
  endfunction

  // Marks the cells that face internal signals rather than pads.
  function automatic logic [BSC_CHAIN_LEN-1:0] bsc_int_mask();
    logic [BSC_CHAIN_LEN-1:0] m;
    m = '0;
    for (int i = 0; i < BSC_INT_COUNT; i++) begin
      m[BSC_CHAIN_LEN - BSC_INT_CELL[i]] = 1'b1;
    end
    return m;
  endfunction

  localparam logic [BSC_CHAIN_LEN-1:0] BSC_OEN_MASK = bsc_oen_mask();
  localparam logic [BSC_CHAIN_LEN-1:0] BSC_INT_MASK = bsc_int_mask();

  // Test access port controller states, one-hot.
  typedef enum logic [15:0] {
    BSC_TLR = 16'h0001,
    BSC_RTI = 16'h0002,
    BSC_SDR = 16'h0004,
    BSC_CDR = 16'h0008,
    BSC_SHDR = 16'h0010,
    BSC_E1DR = 16'h0020,
    BSC_PDR = 16'h0040,
    BSC_E2DR = 16'h0080,
    BSC_UDR = 16'h0100,
    BSC_SIR = 16'h0200,
    BSC_CIR = 16'h0400,
    BSC_SHIR = 16'h0800,
    BSC_E1IR = 16'h1000,
    BSC_PIR = 16'h2000,
    BSC_E2IR = 16'h4000,
    BSC_UIR = 16'h8000
  } bsc_tap_state_t;

  // All state clocked by the rising test clock edge.
  typedef struct packed {
    bsc_tap_state_t st;
    logic [BSC_IR_W-1:0] ir_sh;
    logic [BSC_IR_W-1:0] ir;
    logic [BSC_ID_W-1:0] id_sh;
    logic byp;
    logic [BSC_CHAIN_LEN-1:0] ch_sh;
    logic [BSC_CHAIN_LEN-1:0] ch_upd;
    logic upd_tgl;
    logic [BSC_CHAIN_LEN-1:0] obs_s1;
    logic [BSC_CHAIN_LEN-1:0] obs_s2;
  } bsc_test_st_t;

  // All state clocked by the system clock.
  typedef struct packed {
    logic ext_s1;
    logic ext_s2;
    logic tg_s1;
    logic tg_s2;
    logic tg_s3;
    logic [BSC_CHAIN_LEN-1:0] upd_cp;
    logic [BSC_CHAIN_LEN-1:0] drive;
    logic oe_act;
  } bsc_sys_st_t;

  localparam bsc_test_st_t BSC_TEST_RST = '{
    st: BSC_TLR, ir_sh: '0, ir: BSC_INS_IDCODE, id_sh: '0, byp: 1'b0,
    ch_sh: '0, ch_upd: '0, upd_tgl: 1'b0, obs_s1: '0, obs_s2: '0};

endpackage : bsc_pkg

// ===== hw/bsc_tap_top.sv
// Boundary-scan test access port: controller, instruction, bypass, id and chain registers.
//
// What this block does
// [RL1] One serial chain of 236 cells.
// [RL2] Twenty-eight cells are output-enable cells.
// [RL3] 205 cells serve 117 external signals.
// [RL4] Three cells serve internal reset and select.
// [RL5] Bidirectional pins own adjacent in/out cells.
// [RL6] Clock and PLL pins carry no cells.
// [RL7] Cell order fixed: 1 near input, 236 near output.
// [RL8] Serial data enters MSB, LSB drives out.
// [RL9] Fixed 32-bit identification register, serially readable.
// [RL10] Identification code leaves LSB first.
// [RL11] Data-in and mode-select sampled on rising edge.
// [RL12] Serial output changes only on falling edges and at test reset.
// [RL13] Standard sixteen-state controller steered by mode-select.
// [RL14] Low test reset forces controller reset.
// [RL15] Five mode-select highs reach reset state.
// [RL16] Shifting runs on dedicated test clock only.
// [RL17] Exactly one of four registers shifts.
// [RL18] Chain can drive any pattern on pins.
// [RL19] Data capture loads pin values into chain.
// [RL20] Reset selects identification, clears three top cells.
// [RL21] Instruction capture loads pattern 00000001.
// [RL22] Eight-bit instruction decode with four codes.
// [RL23] Bypass is one cell during shift.
// [RL24] Pin latches change only at data update and reset.
// [RL25] Outside test instructions the chain is transparent.
module bsc_tap_top
  import bsc_pkg::*;
#(
  parameter logic [BSC_ID_W-1:0] IDCODE = BSC_IDCODE_DEFAULT
) (
  // System clock and reset.
  input wire logic clock,
  input wire logic arst_n,
  // Test port.
  input wire logic test_clock,
  input wire logic test_reset_n,
  input wire logic test_mode_select,
  input wire logic test_serial_in,
  output logic test_serial_out,
  output logic test_serial_out_oe,
  // Pad side, one bit per chain cell, bit index = 236 - cell number.
  input wire logic [BSC_CHAIN_LEN-1:0] pin_observe,
  input wire logic [BSC_CHAIN_LEN-1:0] core_drive,
  output logic [BSC_CHAIN_LEN-1:0] pin_drive,
  output logic scan_oe_active
);

  // The chain layout is fixed by the package cell maps: every output-enable, pad and
  // internal cell keeps its printed position, and bidirectional pins keep their in/out
  // pair side by side. Clock and PLL pins are simply absent from the chain. [RL1] [RL3] [RL5] [RL6] [RL7]

  bsc_test_st_t t_ff;
  bsc_test_st_t nxt_t;
  bsc_sys_st_t s_ff;
  bsc_sys_st_t nxt_s;
  logic tdo_ff;
  logic tdo_oe_ff;
  logic nxt_tdo;
  logic nxt_tdo_oe;
  logic sel_chain;
  logic sel_id;
  logic sel_byp;
  logic is_extest;

  // Instruction decode; every code not named selects bypass so an unknown or debug
  // code never lengthens the serial path unexpectedly.
  always_comb begin
    is_extest = (t_ff.ir == BSC_INS_EXTEST); // [RL22]
    sel_chain = is_extest || (t_ff.ir == BSC_INS_SAMPLE); // [RL22]
    sel_id = (t_ff.ir == BSC_INS_IDCODE); // [RL22]
    sel_byp = !sel_chain && !sel_id; // [RL22]
  end

  // Controller next state and register actions, all on the rising test clock edge.
  always_comb begin
    nxt_t = t_ff;
    // Pad values come from outside the test clock domain, so they pass two flops.
    nxt_t.obs_s1 = pin_observe;
    nxt_t.obs_s2 = t_ff.obs_s1;
    // The state walk depends on mode-select alone. [RL13] [RL11]
    case (t_ff.st)
      BSC_TLR: begin
        nxt_t.st = test_mode_select ? BSC_TLR : BSC_RTI; // [RL15]
      end
      BSC_RTI: begin
        nxt_t.st = test_mode_select ? BSC_SDR : BSC_RTI;
      end
      BSC_SDR: begin
        nxt_t.st = test_mode_select ? BSC_SIR : BSC_CDR;
      end
      BSC_CDR: begin
        nxt_t.st = test_mode_select ? BSC_E1DR : BSC_SHDR;
      end
      BSC_SHDR: begin
        nxt_t.st = test_mode_select ? BSC_E1DR : BSC_SHDR;
      end
      BSC_E1DR: begin
        nxt_t.st = test_mode_select ? BSC_UDR : BSC_PDR;
      end
      BSC_PDR: begin
        nxt_t.st = test_mode_select ? BSC_E2DR : BSC_PDR;
      end
      BSC_E2DR: begin
        nxt_t.st = test_mode_select ? BSC_UDR : BSC_SHDR;
      end
      BSC_UDR: begin
        nxt_t.st = test_mode_select ? BSC_SDR : BSC_RTI;
      end
      BSC_SIR: begin
        nxt_t.st = test_mode_select ? BSC_TLR : BSC_CIR; // [RL15]
      end
      BSC_CIR: begin
        nxt_t.st = test_mode_select ? BSC_E1IR : BSC_SHIR;
      end
      BSC_SHIR: begin
        nxt_t.st = test_mode_select ? BSC_E1IR : BSC_SHIR;
      end
      BSC_E1IR: begin
        nxt_t.st = test_mode_select ? BSC_UIR : BSC_PIR;
      end
      BSC_PIR: begin
        nxt_t.st = test_mode_select ? BSC_E2IR : BSC_PIR;
      end
      BSC_E2IR: begin
        nxt_t.st = test_mode_select ? BSC_UIR : BSC_SHIR;
      end
      BSC_UIR: begin
        nxt_t.st = test_mode_select ? BSC_SDR : BSC_RTI;
      end
      default: begin
        nxt_t.st = BSC_TLR;
      end
    endcase

    // Register actions belonging to the current state.
    case (t_ff.st)
      BSC_TLR: begin
        // Reset defaults: identification selected, the three top cells (1 to 3) low in both shift and latch.
        nxt_t.ir = BSC_INS_IDCODE; // [RL20]
        nxt_t.ch_upd[BSC_CHAIN_LEN-1 -: BSC_RST_CLR_CELLS] = '0; // [RL20]
        nxt_t.ch_sh[BSC_CHAIN_LEN-1 -: BSC_RST_CLR_CELLS] = '0; // [RL20]
      end
      BSC_CIR: begin
        nxt_t.ir_sh = BSC_IR_CAPTURE; // [RL21]
      end
      BSC_SHIR: begin
        nxt_t.ir_sh = {test_serial_in, t_ff.ir_sh[BSC_IR_W-1:1]}; // [RL17]
      end
      BSC_UIR: begin
        nxt_t.ir = t_ff.ir_sh; // [RL22]
      end
      BSC_CDR: begin
        if (sel_chain) begin
          nxt_t.ch_sh = t_ff.obs_s2; // [RL19]
        end
        if (sel_id) begin
          nxt_t.id_sh = IDCODE; // [RL9]
        end
        if (sel_byp) begin
          nxt_t.byp = 1'b0; // [RL23]
        end
      end
      BSC_SHDR: begin
        // Only the selected data register moves; the others hold. [RL17]
        if (sel_chain) begin
          nxt_t.ch_sh = {test_serial_in, t_ff.ch_sh[BSC_CHAIN_LEN-1:1]}; // [RL8] [RL18]
        end
        if (sel_id) begin
          nxt_t.id_sh = {test_serial_in, t_ff.id_sh[BSC_ID_W-1:1]}; // [RL10]
        end
        if (sel_byp) begin
          nxt_t.byp = test_serial_in; // [RL23]
        end
      end
      BSC_UDR: begin
        // The pin latches move here and, for the three top cells, in reset, so pins stay still while a
        // new pattern is shifting through the chain.
        if (sel_chain) begin
          nxt_t.ch_upd = t_ff.ch_sh; // [RL24] [RL18]
          nxt_t.upd_tgl = !t_ff.upd_tgl;
        end
      end
      default: begin
      end
    endcase
  end

  // Test clock domain registers; the test reset pin acts at once. [RL14] [RL16]
  always_ff @(posedge test_clock or negedge test_reset_n) begin
    if (!test_reset_n) begin
      t_ff <= BSC_TEST_RST; // [RL14]
    end else begin
      t_ff <= nxt_t;
    end
  end

  // Serial output source: instruction register in the instruction shift, the selected
  // data register in the data shift, released otherwise.
  always_comb begin
    nxt_tdo = tdo_ff;
    nxt_tdo_oe = 1'b0;
    if (t_ff.st == BSC_SHIR) begin
      nxt_tdo = t_ff.ir_sh[0];
      nxt_tdo_oe = 1'b1;
    end else if (t_ff.st == BSC_SHDR) begin
      nxt_tdo_oe = 1'b1;
      if (sel_chain) begin
        nxt_tdo = t_ff.ch_sh[0]; // [RL8]
      end else if (sel_id) begin
        nxt_tdo = t_ff.id_sh[0]; // [RL10]
      end else begin
        nxt_tdo = t_ff.byp; // [RL23]
      end
    end
  end

  // The falling edge retime gives the tester half a period of hold around its
  // rising-edge sample of our output.
  always_ff @(negedge test_clock or negedge test_reset_n) begin
    if (!test_reset_n) begin
      tdo_ff <= 1'b0;
      tdo_oe_ff <= 1'b0;
    end else begin
      tdo_ff <= nxt_tdo; // [RL12]
      tdo_oe_ff <= nxt_tdo_oe; // [RL12]
    end
  end

  assign test_serial_out = tdo_ff;
  assign test_serial_out_oe = tdo_oe_ff;

  // System clock side. The external-test level passes two flops; a new latched
  // pattern is announced by a toggle and copied once the toggle has settled. The
  // latch word is stable for several test clocks after each update, far longer
  // than the three system clocks the copy needs, so no bit can tear.
  always_comb begin
    nxt_s = s_ff;
    nxt_s.ext_s1 = is_extest;
    nxt_s.ext_s2 = s_ff.ext_s1;
    nxt_s.tg_s1 = t_ff.upd_tgl;
    nxt_s.tg_s2 = s_ff.tg_s1;
    nxt_s.tg_s3 = s_ff.tg_s2;
    if (s_ff.tg_s2 != s_ff.tg_s3) begin
      nxt_s.upd_cp = t_ff.ch_upd;
    end
    // Internal reset and select cells never force the core, even under external
    // test, so a scan pattern cannot reset the processor behind the tester.
    if (s_ff.ext_s2) begin
      nxt_s.drive = (s_ff.upd_cp & ~BSC_INT_MASK) | (core_drive & BSC_INT_MASK); // [RL18] [RL4]
    end else begin
      nxt_s.drive = core_drive; // [RL25]
    end
    // Flags that at least one scanned output group is enabled from the chain.
    nxt_s.oe_act = s_ff.ext_s2 && (|(s_ff.upd_cp & BSC_OEN_MASK)); // [RL2]
  end

  // System clock domain registers.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign pin_drive = s_ff.drive;
  assign scan_oe_active = s_ff.oe_act;

endmodule : bsc_tap_top

// ===== sim/bsc_tap_properties.sv
// Port-level assertions for the boundary-scan test access block.
module bsc_tap_properties
  import bsc_pkg::*;
(
  // System side.
  input wire logic clock,
  input wire logic arst_n,
  // Test port.
  input wire logic test_clock,
  input wire logic test_reset_n,
  input wire logic test_mode_select,
  input wire logic test_serial_out,
  input wire logic test_serial_out_oe,
  // Pad side.
  input wire logic [BSC_CHAIN_LEN-1:0] core_drive,
  input wire logic [BSC_CHAIN_LEN-1:0] pin_drive,
  input wire logic scan_oe_active
);
  // Serial output may only move while the test clock is low.
  property p_out_fall;
    @(posedge clock) disable iff (!test_reset_n)
      test_clock && $past(test_clock) |-> $stable(test_serial_out);
  endproperty
  a_out_fall: assert property (p_out_fall) else $error("serial out moved");
  // The test reset pin silences the serial output at once.
  property p_trst;
    @(posedge clock) disable iff (!arst_n)
      !test_reset_n |-> !test_serial_out_oe && !test_serial_out;
  endproperty
  a_trst: assert property (p_trst) else $error("reset left output on");
  // Five highs end any scan.
  property p_five;
    @(posedge test_clock) disable iff (!test_reset_n)
      test_mode_select [*5] |=> !test_serial_out_oe;
  endproperty
  a_five: assert property (p_five) else $error("five highs kept scan");
  // A low mode select keeps the shift state.
  property p_shift_hold;
    @(posedge test_clock) disable iff (!test_reset_n)
      test_serial_out_oe && !test_mode_select |=> test_serial_out_oe;
  endproperty
  a_shift_hold: assert property (p_shift_hold) else $error("shift dropped");
  // A high mode select leaves the shift state.
  property p_shift_exit;
    @(posedge test_clock) disable iff (!test_reset_n)
      test_serial_out_oe && test_mode_select |=> !test_serial_out_oe;
  endproperty
  a_shift_exit: assert property (p_shift_exit) else $error("shift kept");
  // Shift is entered only from a low mode select.
  property p_shift_entry;
    @(posedge test_clock) disable iff (!test_reset_n)
      $rose(test_serial_out_oe) |-> !$past(test_mode_select);
  endproperty
  a_shift_entry: assert property (p_shift_entry) else $error("bad shift entry");
  // Held test reset leaves the pads on core values.
  property p_idle_pins;
    @(posedge clock) disable iff (!arst_n)
      !test_reset_n [*5] |=> pin_drive == $past(core_drive);
  endproperty
  a_idle_pins: assert property (p_idle_pins) else $error("pads not core");
  // Held test reset drops the test enables.
  property p_reset_oe;
    @(posedge clock) disable iff (!arst_n) !test_reset_n [*5] |=> !scan_oe_active;
  endproperty
  a_reset_oe: assert property (p_reset_oe) else $error("enables kept");
  // Main scenarios reached.
  c_extest: cover property (@(posedge clock) $rose(scan_oe_active));
  c_shift: cover property (@(posedge test_clock) $rose(test_serial_out_oe));
  c_five: cover property (@(posedge test_clock) test_mode_select [*5]);
endmodule // bsc_tap_properties

bind bsc_tap_top bsc_tap_properties i_bsc_tap_properties (.clock, .arst_n, .test_clock,
  .test_reset_n, .test_mode_select, .test_serial_out, .test_serial_out_oe, .core_drive,
  .pin_drive, .scan_oe_active);

// ===== sim/bsc_tester.sv
// Tester model that drives the test port from the far side.
module bsc_tester (
  // Test port driven by the tester.
  output logic test_clock,
  output logic test_reset_n,
  output logic test_mode_select,
  output logic test_serial_in,
  // Serial answer from the device.
  input wire logic test_serial_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // The clock rests low between frames.
  initial begin
    test_clock = 1'b0;
    test_reset_n = 1'b0;
    test_mode_select = 1'b1;
    test_serial_in = 1'b0;
  end
  // One 48 ns test clock; odd offsets keep its edges off the system clock edges.
  task automatic tick(input logic m, input logic d, output logic o);
    test_mode_select = m;
    test_serial_in = d;
    #12.3 o = test_serial_out;
    test_clock = 1'b1;
    #24 test_clock = 1'b0;
    // The next tick sets the inputs, so nothing is assigned twice in one step.
    #11.7;
  endtask
  // Idle, capture, shift n bits LSB first, update, back to idle.
  task automatic scan(input logic ir, input int n, input logic [255:0] din,
      output logic [255:0] dout);
    logic o;
    dout = '0;
    tick(1'b0, 1'b0, o);
    tick(1'b0, 1'b0, o);
    tick(1'b1, 1'b0, o);
    if (ir) tick(1'b1, 1'b0, o);
    tick(1'b0, 1'b0, o);
    tick(1'b0, 1'b0, o);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], o);
      dout[i] = o;
    end
    tick(1'b1, 1'b0, o);
    tick(1'b0, 1'b0, o);
  endtask
  // Reset through mode select alone.
  task automatic five_high();
    logic o;
    repeat (5) tick(1'b1, 1'b0, o);
    tick(1'b0, 1'b0, o);
  endtask
  // Long enough for the system side to see the reset.
  task automatic pulse_reset();
    test_reset_n = 1'b0;
    #81 test_reset_n = 1'b1;
  endtask
endmodule // bsc_tester

// ===== sim/testbench.sv
// Self-checking bench for the boundary-scan test access block.
module testbench;
  import bsc_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic test_clock, test_reset_n, test_mode_select, test_serial_in;
  logic test_serial_out, test_serial_out_oe, scan_oe_active;
  logic [BSC_CHAIN_LEN-1:0] pin_observe = '0;
  logic [BSC_CHAIN_LEN-1:0] core_drive = '0;
  logic [BSC_CHAIN_LEN-1:0] pin_drive, pat;
  logic [255:0] so;
  int seed = 23515;
  int err_count = 0;
  int checks = 0;
  always #5 clock = ~clock;
  bsc_tap_top i_bsc_tap_top (.clock, .arst_n, .test_clock, .test_reset_n, .test_mode_select,
    .test_serial_in, .test_serial_out, .test_serial_out_oe, .pin_observe, .core_drive,
    .pin_drive, .scan_oe_active);
  bsc_tester i_bsc_tester (.test_clock, .test_reset_n, .test_mode_select, .test_serial_in,
    .test_serial_out);
  // Counts every compare and reports a mismatch at once.
  task automatic check(input logic [255:0] seen, input logic [255:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Chain-wide random value from the fixed seed.
  function automatic logic [BSC_CHAIN_LEN-1:0] rnd();
    logic [255:0] r;
    for (int i = 0; i < 8; i++) r[i*32 +: 32] = $random(seed);
    return r[BSC_CHAIN_LEN-1:0];
  endfunction
  // Internal cells keep core values even under the external test.
  function automatic logic [BSC_CHAIN_LEN-1:0] ext_pins(input logic [BSC_CHAIN_LEN-1:0] p);
    return (p & ~BSC_INT_MASK) | (core_drive & BSC_INT_MASK);
  endfunction
  task automatic load_ir(input logic [7:0] c);
    i_bsc_tester.scan(1'b1, 8, {248'h0, c}, so);
    check(so[7:0], BSC_IR_CAPTURE);
  endtask
  // Lets the update cross into the system domain.
  task automatic settle();
    repeat (12) @(posedge clock);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // A hung handshake would otherwise run forever.
  initial begin
    #500000;
    err_count++;
    close_out();
  end
  // Main sequence.
  initial begin
    repeat (3) @(posedge clock);
    arst_n <= 1'b1;
    i_bsc_tester.pulse_reset();
    i_bsc_tester.scan(1'b0, 32, '0, so);
    check(so[31:0], BSC_IDCODE_DEFAULT);
    for (int k = 0; k < 2; k++) begin
      load_ir(k == 0 ? BSC_INS_BYPASS : 8'h04 + 8'($random(seed) & 8'h7F));
      pat = rnd();
      i_bsc_tester.scan(1'b0, 64, {192'h0, pat[63:0]}, so);
      check(so[63:0], {pat[62:0], 1'b0});
    end
    $display("bypass test done");
    @(posedge clock);
    core_drive <= rnd();
    pin_observe <= rnd();
    load_ir(BSC_INS_SAMPLE);
    pat = rnd();
    i_bsc_tester.scan(1'b0, 236, {20'h0, pat}, so);
    check(so[235:0], pin_observe);
    settle();
    check(pin_drive, core_drive);
    load_ir(BSC_INS_EXTEST);
    settle();
    check(pin_drive, ext_pins(pat));
    check(scan_oe_active, |(pat & BSC_OEN_MASK));
    @(posedge clock);
    pin_observe <= rnd();
    i_bsc_tester.scan(1'b0, 236, {20'h0, ~pat}, so);
    check(so[235:0], pin_observe);
    settle();
    check(pin_drive, ext_pins(~pat));
    $display("chain test done");
    i_bsc_tester.five_high();
    settle();
    check(pin_drive, core_drive);
    i_bsc_tester.scan(1'b0, 32, '0, so);
    check(so[31:0], BSC_IDCODE_DEFAULT);
    load_ir(BSC_INS_BYPASS);
    i_bsc_tester.pulse_reset();
    i_bsc_tester.scan(1'b0, 32, '0, so);
    check(so[31:0], BSC_IDCODE_DEFAULT);
    $display("reset test done");
    close_out();
  end
endmodule // testbench
